//--- lvd_pkg.sv
// Shared constants and types for the low voltage detector control block
package lvd_pkg;

    // Clock and delay timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned IRQ_DELAY_NS = 15000;
    localparam int unsigned IRQ_DELAY_CYCLES = (IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_DELAY_NS = 15000;
    localparam int unsigned SETTLE_DELAY_CYCLES = (SETTLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DLY_CNT_W = 11;
    localparam logic [DLY_CNT_W-1:0] DLY_CNT_ZERO = 11'h000;
    localparam logic [DLY_CNT_W-1:0] DLY_CNT_ONE = 11'h001;
    localparam logic [DLY_CNT_W-1:0] DLY_CNT_LAST = DLY_CNT_W'(IRQ_DELAY_CYCLES - 1);

    // Bus geometry
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BE_W = 4;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 5'h00;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 5'h04;
    localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFFSET = 5'h08;
    localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFFSET = 5'h0C;
    localparam logic [ADDR_W-1:0] IRQ_FORCE_OFFSET = 5'h10;

    // Control register fields
    localparam int unsigned THR_LSB = 0;
    localparam int unsigned THR_MSB = 2;
    localparam int unsigned ENABLE_BIT = 4;
    localparam int unsigned FLAG_BIT = 5;
    localparam int unsigned CTRL_W = 8;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

    // Interrupt register fields
    localparam int unsigned IRQ_W = 1;
    localparam int unsigned IRQ_FLAG_BIT = 0;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 1'h0;

    // Threshold codes; the last one switches to the external sense pin at 1.25 V
    localparam logic [2:0] THR_2V0 = 3'h0;
    localparam logic [2:0] THR_2V2 = 3'h1;
    localparam logic [2:0] THR_2V4 = 3'h2;
    localparam logic [2:0] THR_2V7 = 3'h3;
    localparam logic [2:0] THR_3V0 = 3'h4;
    localparam logic [2:0] THR_3V3 = 3'h5;
    localparam logic [2:0] THR_3V6 = 3'h6;
    localparam logic [2:0] THR_EXTERNAL = 3'h7;

    // Comparator synchroniser depth
    localparam int unsigned SYNC_STAGES = 3;

    // Register select, one-hot
    typedef enum logic [5:0] {
        SEL_NONE = 6'b000001,
        SEL_CTRL = 6'b000010,
        SEL_STATUS = 6'b000100,
        SEL_CLEAR = 6'b001000,
        SEL_ENABLE = 6'b010000,
        SEL_FORCE = 6'b100000
    } reg_sel_type;

    // Delay counter states, one-hot
    typedef enum logic [2:0] {
        DLY_IDLE = 3'b001,
        DLY_COUNT = 3'b010,
        DLY_DONE = 3'b100
    } delay_state_type;

    // Software-held control fields
    typedef struct packed {
        logic enable;
        logic [2:0] threshold;
    } ctrl_type;

    // Controls handed to the analog comparator
    typedef struct packed {
        logic power;
        logic sense_select;
        logic [2:0] threshold;
    } analog_ctrl_type;

endpackage

//--- lvd_irq_delay.sv
`timescale 1ns/1ps
`default_nettype none
// Holds off the interrupt until the low level has lasted the full delay
module lvd_irq_delay (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic level,
    output logic fire
);

    lvd_pkg::delay_state_type state_r;
    lvd_pkg::delay_state_type state_nxt;
    logic [lvd_pkg::DLY_CNT_W-1:0] cnt_r;
    logic [lvd_pkg::DLY_CNT_W-1:0] cnt_nxt;
    logic fire_r;
    logic fire_nxt;

    // Count while low; any fall of the level restarts from zero
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        fire_nxt = 1'b0;
        case (state_r)
            lvd_pkg::DLY_IDLE: begin
                cnt_nxt = lvd_pkg::DLY_CNT_ZERO;
                if (level) begin
                    state_nxt = lvd_pkg::DLY_COUNT;
                end
            end
            lvd_pkg::DLY_COUNT: begin
                if (!level) begin
                    state_nxt = lvd_pkg::DLY_IDLE;
                end else if (cnt_r == lvd_pkg::DLY_CNT_LAST) begin
                    state_nxt = lvd_pkg::DLY_DONE;
                    fire_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + lvd_pkg::DLY_CNT_ONE;
                end
            end
            lvd_pkg::DLY_DONE: begin
                // One fire per low episode, so a held flag cannot retrigger
                if (!level) begin
                    state_nxt = lvd_pkg::DLY_IDLE;
                end
            end
            default: begin
                state_nxt = lvd_pkg::DLY_IDLE;
                cnt_nxt = lvd_pkg::DLY_CNT_ZERO;
            end
        endcase
    end

    // State registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= lvd_pkg::DLY_IDLE;
            cnt_r <= lvd_pkg::DLY_CNT_ZERO;
            fire_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            fire_r <= fire_nxt;
        end
    end

    assign fire = fire_r;

endmodule // lvd_irq_delay
`default_nettype wire

//--- lvd_control.sv
// Overview of operation
// - Three-bit threshold field, seven supply thresholds
// - Code 111 compares sense pin to 1.25 V
// - Bit 5 reads comparator: one means low
// - Enable bit 4 switches detector on/off
// - Bits 7, 6 and 3 read zero
// - Sleep forces detector off despite enable
// - Flag follows comparator, no hysteresis
// - Interrupt flag set after fixed delay
// - Interrupt flag requests interrupt, wakes idle
`timescale 1ns/1ps
`default_nettype none
module lvd_control (
    input wire logic sys_clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [lvd_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [lvd_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [lvd_pkg::BE_W-1:0] avs_byteenable,
    output logic [lvd_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Analog comparator side
    input wire logic comparator_low,
    output lvd_pkg::analog_ctrl_type analog_ctrl,
    // Power mode side
    input wire logic sleep_mode,
    input wire logic idle_mode,
    output logic wake_idle,
    output logic irq
);

    // Decode a byte address into a one-hot register select
    function automatic lvd_pkg::reg_sel_type reg_decode(input logic [lvd_pkg::ADDR_W-1:0] addr);
        lvd_pkg::reg_sel_type sel;
        sel = lvd_pkg::SEL_NONE;
        case (addr)
            lvd_pkg::CTRL_OFFSET: begin
                sel = lvd_pkg::SEL_CTRL;
            end
            lvd_pkg::IRQ_STATUS_OFFSET: begin
                sel = lvd_pkg::SEL_STATUS;
            end
            lvd_pkg::IRQ_CLEAR_OFFSET: begin
                sel = lvd_pkg::SEL_CLEAR;
            end
            lvd_pkg::IRQ_ENABLE_OFFSET: begin
                sel = lvd_pkg::SEL_ENABLE;
            end
            lvd_pkg::IRQ_FORCE_OFFSET: begin
                sel = lvd_pkg::SEL_FORCE;
            end
            default: begin
                sel = lvd_pkg::SEL_NONE;
            end
        endcase
        return sel;
    endfunction

    // Bus handshake state
    logic wait_r;
    logic wait_nxt;
    logic [lvd_pkg::DATA_W-1:0] rdata_r;
    logic [lvd_pkg::DATA_W-1:0] rdata_nxt;

    // Software state
    lvd_pkg::ctrl_type ctrl_r;
    lvd_pkg::ctrl_type ctrl_nxt;
    logic [lvd_pkg::IRQ_W-1:0] status_r;
    logic [lvd_pkg::IRQ_W-1:0] status_nxt;
    logic [lvd_pkg::IRQ_W-1:0] enable_r;
    logic [lvd_pkg::IRQ_W-1:0] enable_nxt;

    // Outputs and detector state
    lvd_pkg::analog_ctrl_type analog_r;
    lvd_pkg::analog_ctrl_type analog_nxt;
    logic irq_r;
    logic irq_nxt;
    logic wake_r;
    logic wake_nxt;
    logic [lvd_pkg::SYNC_STAGES-1:0] sync_r;
    logic [lvd_pkg::SYNC_STAGES-1:0] sync_nxt;
    logic stable_r;
    logic stable_nxt;
    logic flag_r;
    logic flag_nxt;

    // Shared decode terms
    lvd_pkg::reg_sel_type sel;
    logic req;
    logic commit;
    logic wr_commit;
    logic byte0_en;
    logic [lvd_pkg::CTRL_W-1:0] ctrl_view;
    logic delay_fire;
    logic irq_set;

    assign sel = reg_decode(avs_address);
    assign req = avs_read | avs_write;
    // The transfer ends at the edge where waitrequest is seen low
    assign commit = req & ~wait_r;
    assign wr_commit = commit & avs_write;
    assign byte0_en = avs_byteenable[0];

    // Control readback, unimplemented bits tied low
    always_comb begin
        ctrl_view = lvd_pkg::CTRL_RESET;
        ctrl_view[lvd_pkg::THR_MSB:lvd_pkg::THR_LSB] = ctrl_r.threshold;
        ctrl_view[lvd_pkg::ENABLE_BIT] = ctrl_r.enable;
        ctrl_view[lvd_pkg::FLAG_BIT] = flag_r;
    end

    // Bus handshake: one wait cycle, read data latched before release
    always_comb begin
        wait_nxt = wait_r;
        rdata_nxt = rdata_r;
        if (req && wait_r) begin
            wait_nxt = 1'b0;
            rdata_nxt = lvd_pkg::DATA_ZERO;
            if (avs_read) begin
                case (sel)
                    lvd_pkg::SEL_CTRL: begin
                        rdata_nxt[lvd_pkg::CTRL_W-1:0] = ctrl_view;
                    end
                    lvd_pkg::SEL_STATUS: begin
                        rdata_nxt[lvd_pkg::IRQ_W-1:0] = status_r;
                    end
                    lvd_pkg::SEL_ENABLE: begin
                        rdata_nxt[lvd_pkg::IRQ_W-1:0] = enable_r;
                    end
                    default: begin
                        // Write-only and unmapped words read as zero
                        rdata_nxt = lvd_pkg::DATA_ZERO;
                    end
                endcase
            end
        end else if (commit) begin
            wait_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 1'b1;
            rdata_r <= lvd_pkg::DATA_ZERO;
        end else begin
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Control and interrupt enable writes
    always_comb begin
        ctrl_nxt = ctrl_r;
        enable_nxt = enable_r;
        if (wr_commit && byte0_en) begin
            case (sel)
                lvd_pkg::SEL_CTRL: begin
                    ctrl_nxt.threshold = avs_writedata[lvd_pkg::THR_MSB:lvd_pkg::THR_LSB];
                    ctrl_nxt.enable = avs_writedata[lvd_pkg::ENABLE_BIT];
                end
                lvd_pkg::SEL_ENABLE: begin
                    enable_nxt = avs_writedata[lvd_pkg::IRQ_W-1:0];
                end
                default: begin
                    ctrl_nxt = ctrl_r;
                    enable_nxt = enable_r;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= lvd_pkg::ctrl_type'{enable: lvd_pkg::CTRL_RESET[lvd_pkg::ENABLE_BIT],
                threshold: lvd_pkg::CTRL_RESET[lvd_pkg::THR_MSB:lvd_pkg::THR_LSB]};
            enable_r <= lvd_pkg::IRQ_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
            enable_r <= enable_nxt;
        end
    end

    // Analog controls: sleep overrides enable, code 111 selects the sense pin
    always_comb begin
        analog_nxt.power = ctrl_nxt.enable & ~sleep_mode;
        analog_nxt.sense_select = (ctrl_nxt.threshold == lvd_pkg::THR_EXTERNAL);
        analog_nxt.threshold = ctrl_nxt.threshold;
    end

    // Comparator synchroniser; a change counts once stages two and three agree
    always_comb begin
        sync_nxt = {sync_r[lvd_pkg::SYNC_STAGES-2:0], comparator_low};
        stable_nxt = stable_r;
        if (sync_r[1] == sync_r[2]) begin
            stable_nxt = sync_r[2];
        end
        // No hysteresis: slow inputs near threshold may toggle the flag
        flag_nxt = analog_r.power & stable_r;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_r <= '0;
            sync_r <= '0;
            stable_r <= 1'b0;
            flag_r <= 1'b0;
        end else begin
            analog_r <= analog_nxt;
            sync_r <= sync_nxt;
            stable_r <= stable_nxt;
            flag_r <= flag_nxt;
        end
    end

    // Delay from flag rise to interrupt flag set
    lvd_irq_delay u_irq_delay (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .level(flag_r),
        .fire(delay_fire)
    );

    // Software may preset the flag so a later detection brings no wake
    assign irq_set = delay_fire | (wr_commit & byte0_en & (sel == lvd_pkg::SEL_FORCE)
                     & avs_writedata[lvd_pkg::IRQ_FLAG_BIT]);

    // Sticky status; a set in the same cycle as a clear wins
    always_comb begin
        status_nxt = status_r;
        if (wr_commit && byte0_en && (sel == lvd_pkg::SEL_CLEAR)) begin
            status_nxt = status_r & ~avs_writedata[lvd_pkg::IRQ_W-1:0];
        end
        if (delay_fire) begin
            status_nxt[lvd_pkg::IRQ_FLAG_BIT] = 1'b1;
        end
        if (irq_set) begin
            status_nxt[lvd_pkg::IRQ_FLAG_BIT] = 1'b1;
        end
        irq_nxt = |(status_nxt & enable_nxt);
        // Wake only on a fresh detection; a preset flag blocks it
        wake_nxt = delay_fire & ~status_r[lvd_pkg::IRQ_FLAG_BIT] & idle_mode;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= lvd_pkg::IRQ_RESET;
            irq_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_r <= irq_nxt;
            wake_r <= wake_nxt;
        end
    end

    // All outputs come straight from flip-flops
    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign analog_ctrl = analog_r;
    assign irq = irq_r;
    assign wake_idle = wake_r;

endmodule // lvd_control
`default_nettype wire

//--- lvd_control_pad.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- lvd_control_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the detector control block
module lvd_control_sva (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [lvd_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [lvd_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic comparator_low,
    input wire lvd_pkg::analog_ctrl_type analog_ctrl,
    input wire logic sleep_mode,
    input wire logic idle_mode,
    input wire logic wake_idle
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic ctrl_rd;
    logic [11:0] low_run_r;
    logic [11:0] low_run_nxt;
    assign ctrl_rd = avs_read && !avs_waitrequest && avs_address == lvd_pkg::CTRL_OFFSET;
    // Length of the present powered low episode; saturates so it never wraps
    always_comb begin
        low_run_nxt = (comparator_low && analog_ctrl.power) ? low_run_r + 12'h001 : 12'h000;
        if (low_run_r == 12'hFFF) low_run_nxt = low_run_r;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) low_run_r <= 12'h000;
        else low_run_r <= low_run_nxt;
    end
    a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    a_sense_select: assert property (analog_ctrl.sense_select == (analog_ctrl.threshold == 3'h7))
        else $error("sense select does not follow code");
    a_sleep_off: assert property (sleep_mode |=> !analog_ctrl.power)
        else $error("detector powered in sleep");
    a_reserved_zero: assert property (ctrl_rd |-> avs_readdata[7:6] == 2'h0 && !avs_readdata[3])
        else $error("unused control bits not zero");
    a_ctrl_mirror: assert property (ctrl_rd && !$past(sleep_mode) |->
        avs_readdata[4] == analog_ctrl.power && avs_readdata[2:0] == analog_ctrl.threshold)
        else $error("control fields differ from detector controls");
    a_flag_unpowered: assert property (ctrl_rd && !$past(analog_ctrl.power) &&
        !$past(analog_ctrl.power, 2) && !$past(analog_ctrl.power, 3) |-> !avs_readdata[5])
        else $error("flag set while detector off");
    a_wake_pulse: assert property (wake_idle |-> $past(idle_mode) ##1 !wake_idle)
        else $error("wake pulse outside idle or too long");
    a_irq_delay: assert property ($rose(wake_idle) |-> low_run_r >= lvd_pkg::IRQ_DELAY_CYCLES)
        else $error("wake before the full delay");
endmodule // lvd_control_sva
bind lvd_control lvd_control_sva chk (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .comparator_low, .analog_ctrl, .sleep_mode, .idle_mode, .wake_idle);
`default_nettype wire

//--- lvd_comparator_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural comparator; its output is meaningless while unpowered
module lvd_comparator_model (
    input wire logic sys_clk,
    input wire lvd_pkg::analog_ctrl_type analog_ctrl,
    input wire logic [15:0] supply_mv,
    input wire logic [15:0] sense_mv,
    output logic comparator_low
);
    int thr_tab[8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 1250};
    logic junk_r = 1'b0;
    // Changes every cycle so an unpowered output cannot pass for a result
    always @(posedge sys_clk) junk_r <= ~junk_r;
    // Sense pin on the last code, supply otherwise; no hysteresis
    assign comparator_low = !analog_ctrl.power ? junk_r :
        ((analog_ctrl.sense_select ? sense_mv : supply_mv) < thr_tab[analog_ctrl.threshold]);
endmodule // lvd_comparator_model
`default_nettype wire

//--- low_voltage_detect_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Bus reads are noted by the driver and compared by a separate monitor
module low_voltage_detect_control_tb_top;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic comparator_low;
    lvd_pkg::analog_ctrl_type analog_ctrl;
    logic sleep_mode = 1'b0;
    logic idle_mode = 1'b0;
    logic wake_idle;
    logic irq;
    logic [15:0] supply_mv = 16'hBB8;
    logic [15:0] sense_mv = 16'h5DC;
    logic [31:0] exp_q[$];
    logic [31:0] wd;
    logic [2:0] cc;
    int thr_tab[8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 1250};
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int wake_count = 0;
    int t0;
    always #4 sys_clk = ~sys_clk;
    lvd_control dut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .comparator_low, .analog_ctrl, .sleep_mode, .idle_mode, .wake_idle, .irq);
    lvd_comparator_model partner (.sys_clk, .analog_ctrl, .supply_mv, .sense_mv, .comparator_low);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One transfer, held until waitrequest is seen low
    task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b1, a, 32'h0, 4'hF);
    endtask
    function automatic logic low(input logic [2:0] c);
        return (c == 3'h7 ? sense_mv : supply_mv) < thr_tab[c];
    endfunction
    // Monitor: timeout, wake count, oldest note against each read result
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 12000) begin
            err_count++;
            give_verdict();
        end
        if (wake_idle === 1'b1) wake_count++;
        if (avs_read && avs_waitrequest === 1'b0) check(avs_readdata, exp_q.pop_front());
    end
    initial begin
        wd = $urandom(32'hE397);
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Reset values; write-only and unmapped places read zero
        rd(5'h00, 32'h0);
        rd(5'h04, 32'h0);
        rd(5'h08, 32'h0);
        rd(5'h14, 32'h0);
        // Let the detector settle once before any flag value is trusted
        bus(1'b0, 5'h00, 32'h10, 4'hF);
        repeat (lvd_pkg::SETTLE_DELAY_CYCLES) @(posedge sys_clk);
        // Every code with random levels; junk aimed at the read-only bits
        for (int c = 0; c < 8; c++) begin
            cc = c[2:0];
            supply_mv <= 16'($urandom_range(3800, 1800));
            sense_mv <= 16'($urandom_range(1500, 1000));
            wd = ($urandom & 32'hFFFF_FFE8) | 32'h10 | 32'(cc);
            bus(1'b0, 5'h00, wd, 4'hF);
            repeat (8) @(posedge sys_clk);
            rd(5'h00, {26'h0, low(cc), 2'b10, cc});
        end
        // Flag follows a level dithering round the threshold
        bus(1'b0, 5'h00, 32'h13, 4'hF);
        for (int k = 0; k < 4; k++) begin
            supply_mv <= k[0] ? 16'd2710 : 16'd2690;
            repeat (8) @(posedge sys_clk);
            rd(5'h00, {26'h0, !k[0], 5'h13});
        end
        // Detector off, ignored byte lane, then sleep over a set enable
        bus(1'b0, 5'h00, 32'h03, 4'hF);
        bus(1'b0, 5'h00, 32'h13, 4'h0);
        repeat (8) @(posedge sys_clk);
        rd(5'h00, 32'h03);
        bus(1'b0, 5'h00, 32'h13, 4'hF);
        sleep_mode <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(5'h00, 32'h13);
        check(analog_ctrl.power, 32'h0);
        sleep_mode <= 1'b0;
        supply_mv <= 16'd3000;
        bus(1'b0, 5'h0C, 32'h1, 4'hF);
        idle_mode <= 1'b1;
        // Back from sleep the detector is powered again and must settle
        repeat (lvd_pkg::SETTLE_DELAY_CYCLES) @(posedge sys_clk);
        // Low episode cut short; the delay restarts from the last fall
        supply_mv <= 16'd2000;
        repeat (1000) @(posedge sys_clk);
        supply_mv <= 16'd3000;
        repeat (20) @(posedge sys_clk);
        supply_mv <= 16'd2000;
        t0 = cycles;
        repeat (3000) begin
            @(posedge sys_clk);
            if (wake_idle === 1'b1) break;
        end
        t0 = cycles - t0;
        check(32'(t0 >= lvd_pkg::IRQ_DELAY_CYCLES + 3 && t0 <= lvd_pkg::IRQ_DELAY_CYCLES + 9), 32'h1);
        repeat (2) @(posedge sys_clk);
        check(irq, 32'h1);
        rd(5'h04, 32'h1);
        idle_mode <= 1'b0;
        // Clear holds while still low; masked forced flag keeps irq low
        bus(1'b0, 5'h08, 32'h1, 4'hF);
        rd(5'h04, 32'h0);
        check(irq, 32'h0);
        bus(1'b0, 5'h0C, 32'h0, 4'hF);
        bus(1'b0, 5'h10, 32'h1, 4'hF);
        rd(5'h0C, 32'h0);
        rd(5'h04, 32'h1);
        check(irq, 32'h0);
        bus(1'b0, 5'h0C, 32'h1, 4'hF);
        repeat (3) @(posedge sys_clk);
        check(irq, 32'h1);
        // Preset flag: a new episode in idle must not wake
        supply_mv <= 16'd3000;
        repeat (20) @(posedge sys_clk);
        // Idle is entered only once the flag has been preset
        idle_mode <= 1'b1;
        supply_mv <= 16'd2000;
        repeat (2000) @(posedge sys_clk);
        check(32'(wake_count), 32'h1);
        give_verdict();
    end
endmodule // low_voltage_detect_control_tb_top
`default_nettype wire
